/* File: asc_pkg.sv */
// asc_pkg: shared constants for the converter sequencer control block.
// assumes a 32-bit classic Wishbone slave, one 8-bit register per word.
package asc_pkg;
  // ----------------------------------------------------------------
  // register map (word indices, matched against address bits 31:2)
  // ----------------------------------------------------------------
  localparam logic [7:0] ASC_CTRL0_OFS = 8'h1F;  // converter_control_zero index
  localparam logic [7:0] ASC_CLKCFG_OFS = 8'h9F; // converter_clock_config index
  localparam logic [7:0] ASC_PINSEL_OFS = 8'h91; // analog_pin_select index
  localparam logic [7:0] ASC_RESHI_OFS = 8'h1E;  // result_high_byte index
  localparam logic [7:0] ASC_RESLO_OFS = 8'h9E;  // result_low_byte index
  localparam logic [7:0] ASC_FLAG_OFS = 8'h0C;   // peripheral_flag_reg index
  localparam logic [7:0] ASC_IEN_OFS = 8'h8C;    // interrupt enable index
  localparam logic [7:0] ASC_DIR_OFS = 8'h85;    // port_a_direction index
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int ASC_ON_BIT = 0;
  localparam int ASC_GO_BIT = 1;
  localparam int ASC_CHS_LSB = 2;
  localparam int ASC_REF_BIT = 6;
  localparam int ASC_JUST_BIT = 7;
  localparam int ASC_CKS_LSB = 4;
  localparam int ASC_DONE_BIT = 6;
  localparam logic [7:0] ASC_CTRL0_WMASK = 8'hDF; // bit 5 not implemented
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ASC_CTRL0_RST = 8'h00;
  localparam logic [2:0] ASC_CKS_RST = 3'h0;
  localparam logic [7:0] ASC_PINSEL_RST = 8'hFF;
  localparam logic [5:0] ASC_DIR_RST = 6'h3F;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int ASC_CONV_TAD = 11;  // periods per conversion
  localparam int ASC_ABORT_TAD = 2;  // recovery after abort
  localparam int ASC_RES_BITS = 10;
  typedef enum logic [1:0] {
    ASC_IDLE = 2'b00,
    ASC_WAIT = 2'b01,
    ASC_CONV = 2'b10,
    ASC_RECOV = 2'b11
  } asc_state_type;
endpackage

/* File: asc_ctrl.sv */
// asc_ctrl: control sequencer for a 10-bit successive-approximation converter.
// assumes the analog core presents one result bit per period on sar_bit_i.
// assumes the bus master holds each request until it samples ack high.
//
// Summary of operation
// - ten-bit successive approximation, one shared sample-and-hold through a mux.
// - channel select bits 4:2 of control zero route input n.
// - reference bit 6 set picks external reference pin, clear picks supply.
// - a conversion lasts eleven conversion clock periods.
// - clock select bits 6:4 of clock config pick divider or internal RC.
// - writing go starts a conversion; go reads one while busy.
// - completion clears go, sets done flag bit 6, requests interrupt if enabled.
// - clearing go mid-conversion aborts; results keep previous value.
// - after abort wait two periods, then acquire the selected channel.
// - justify bit 7 set right-justifies result, clear left-justifies.
// - power-on bit 0 enables converter; clear shuts it off.
// - bit 5 of control zero reads zero and ignores writes.
// - pin select disables digital input buffers; direction bit floats driver.
// - reset turns converter off, aborts conversion, keeps result registers.
// - sleep with non-RC clock aborts and turns module off, enable stays.
// - RC clock waits one instruction, completes and loads results in sleep.
`timescale 1ns/1ps
module asc_ctrl import asc_pkg::*; #(
  parameter int RC_DIV = 800  // system clocks per RC period
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  input wire logic sleep_i,
  input wire logic instr_tick_i,
  input wire logic sar_bit_i,
  output logic [2:0] input_channel_select_o,
  output logic reference_source_select_o,
  output logic converter_power_on_o,
  output logic sample_o,
  output logic sar_step_o,
  output logic [7:0] pin_analog_enable_o,
  output logic [5:0] port_a_direction_o,
  output logic irq_o
);
  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
    hit = (a[31:2] == {22'h0, idx});
  endfunction
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire wr0 = req & wb_we_i & wb_sel_i[0];
  wire hit_c0 = hit(wb_adr_i, ASC_CTRL0_OFS);
  wire hit_ck = hit(wb_adr_i, ASC_CLKCFG_OFS);
  wire hit_ps = hit(wb_adr_i, ASC_PINSEL_OFS);
  wire hit_hi = hit(wb_adr_i, ASC_RESHI_OFS);
  wire hit_lo = hit(wb_adr_i, ASC_RESLO_OFS);
  wire hit_fl = hit(wb_adr_i, ASC_FLAG_OFS);
  wire hit_ie = hit(wb_adr_i, ASC_IEN_OFS);
  wire hit_dr = hit(wb_adr_i, ASC_DIR_OFS);
  wire [7:0] wd = wb_dat_i[7:0];

  logic [7:0] ctrl0_r;
  logic [2:0] cks_r;
  logic [7:0] pinsel_r;
  logic [5:0] dir_r;
  logic [7:0] res_hi_r, res_lo_r;
  logic done_r, ien_r;
  asc_state_type st_r, st_nxt;
  logic [3:0] tad_cnt_r;
  logic [9:0] sar_r;
  logic [9:0] div_r;
  logic [6:0] pre_r;
  logic tick;

  // ----------------------------------------------------------------
  // conversion clock divider
  // ----------------------------------------------------------------
  // one ratio decode; x11 runs off a slow count standing in for the RC source
  wire rc_sel = (cks_r[1:0] == 2'b11);
  wire [6:0] ratio = cks_r == 3'b000 ? 7'h02 : cks_r == 3'b100 ? 7'h04 :
                     cks_r == 3'b001 ? 7'h08 : cks_r == 3'b101 ? 7'h10 :
                     cks_r == 3'b010 ? 7'h20 : 7'h40;
  // restart on every state change so each phase gets whole periods
  always_ff @(posedge clk_i) begin
    if (rst_i || st_r == ASC_IDLE || st_nxt != st_r) begin
      pre_r <= 7'h00;
      div_r <= 10'h000;
    end else if (rc_sel) begin
      div_r <= (div_r == 10'(RC_DIV - 1)) ? 10'h000 : div_r + 10'h001;
    end else begin
      pre_r <= (pre_r == ratio - 7'h01) ? 7'h00 : pre_r + 7'h01;
    end
  end
  assign tick = rc_sel ? (div_r == 10'(RC_DIV - 1)) : (pre_r == ratio - 7'h01);

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // sleep with a divided clock kills the conversion; the rc clock keeps running
  wire on = ctrl0_r[ASC_ON_BIT];
  wire go = ctrl0_r[ASC_GO_BIT];
  wire sleep_kill = sleep_i & ~rc_sel;
  wire busy = (st_r == ASC_WAIT) || (st_r == ASC_CONV);
  wire finish = (st_r == ASC_CONV) && tick && (tad_cnt_r == 4'(ASC_CONV_TAD - 1));
  wire abort = busy & (~go | ~on | sleep_kill);
  always_comb begin
    st_nxt = st_r;
    case (st_r)
      ASC_IDLE: if (go && on && !sleep_kill) begin
        st_nxt = rc_sel ? ASC_WAIT : ASC_CONV;
      end
      ASC_WAIT: if (abort) begin
        st_nxt = ASC_RECOV;
      end else if (instr_tick_i) begin
        st_nxt = ASC_CONV;
      end
      ASC_CONV: if (abort) begin
        st_nxt = ASC_RECOV;
      end else if (finish) begin
        st_nxt = ASC_IDLE;
      end
      ASC_RECOV: if (tick && tad_cnt_r == 4'(ASC_ABORT_TAD - 1)) begin
        st_nxt = ASC_IDLE;
      end
      default: st_nxt = ASC_IDLE;
    endcase
  end
  // state and period count; reset drops any conversion in flight
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= ASC_IDLE;
      tad_cnt_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) tad_cnt_r <= 4'h0;
      else if (tick) tad_cnt_r <= tad_cnt_r + 4'h1;
    end
  end
  // one decision per period for the first ten periods; the eleventh only closes out
  wire step = (st_r == ASC_CONV) && tick && (tad_cnt_r < 4'(ASC_RES_BITS));
  // shift one decision per period, msb first
  always_ff @(posedge clk_i) begin
    if (step) begin
      sar_r <= {sar_r[8:0], sar_bit_i};
    end
  end
  // result registers have no reset, so they survive a device reset
  always_ff @(posedge clk_i) begin
    if (finish && !abort) begin
      if (ctrl0_r[ASC_JUST_BIT]) begin
        res_hi_r <= {6'h00, sar_r[9:8]};
        res_lo_r <= sar_r[7:0];
      end else begin
        res_hi_r <= sar_r[9:2];
        res_lo_r <= {sar_r[1:0], 6'h00};
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  // hardware set/clear of go and done beats a same-cycle software write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl0_r <= ASC_CTRL0_RST;
      cks_r <= ASC_CKS_RST;
      pinsel_r <= ASC_PINSEL_RST;
      dir_r <= ASC_DIR_RST;
      done_r <= 1'b0;
      ien_r <= 1'b0;
    end else begin
      if (wr0 && hit_c0) ctrl0_r <= wd & ASC_CTRL0_WMASK;
      if (wr0 && hit_ck) cks_r <= wd[ASC_CKS_LSB +: 3];
      if (wr0 && hit_ps) pinsel_r <= wd;
      if (wr0 && hit_dr) dir_r <= wd[5:0];
      if (wr0 && hit_ie) ien_r <= wd[ASC_DONE_BIT];
      if (wr0 && hit_fl) done_r <= wd[ASC_DONE_BIT];
      if (finish && !abort) begin
        ctrl0_r[ASC_GO_BIT] <= 1'b0;
        done_r <= 1'b1;
      end else if ((st_r == ASC_IDLE && !on) || (busy && sleep_kill)) begin
        ctrl0_r[ASC_GO_BIT] <= 1'b0;
      end
    end
  end

  // read mux and single-cycle ack; unmapped reads return zero
  wire [7:0] rd = hit_c0 ? ctrl0_r :
                  hit_ck ? {1'b0, cks_r, 4'h0} :
                  hit_ps ? pinsel_r :
                  hit_hi ? res_hi_r :
                  hit_lo ? res_lo_r :
                  hit_fl ? {1'b0, done_r, 6'h00} :
                  hit_ie ? {1'b0, ien_r, 6'h00} :
                  hit_dr ? {2'b00, dir_r} : 8'h00;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= {24'h0, rd};
    end
  end

  // ----------------------------------------------------------------
  // analog side outputs
  // ----------------------------------------------------------------
  assign input_channel_select_o = ctrl0_r[ASC_CHS_LSB +: 3];
  assign reference_source_select_o = ctrl0_r[ASC_REF_BIT];
  // powered only while enabled and not shut down by sleep
  assign converter_power_on_o = on & ~(sleep_i & ~rc_sel);
  // acquisition runs whenever the converter sits idle with power-on bit 0 set, even while sleep holds the power output low
  assign sample_o = on & (st_r == ASC_IDLE);
  assign sar_step_o = step;
  assign pin_analog_enable_o = pinsel_r;
  assign port_a_direction_o = dir_r;
  assign irq_o = done_r & ien_r;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  // bit 5 resets to zero and is masked off every write, so it can never read back as one
  property p_bit5; @(posedge clk_i) disable iff (rst_i) ctrl0_r[5] == 1'b0; endproperty
  a_bit5: assert property (p_bit5) else $error("bit 5 set");
  property p_done; @(posedge clk_i) disable iff (rst_i)
    (finish && !abort) |=> (done_r && !ctrl0_r[ASC_GO_BIT]); endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_abort; @(posedge clk_i) disable iff (rst_i)
    (abort) |=> $stable(res_hi_r) && $stable(res_lo_r); endproperty
  a_abort: assert property (p_abort) else $error("result changed");
  property p_off; @(posedge clk_i) disable iff (rst_i)
    (st_r == ASC_IDLE && !on) |=> st_r == ASC_IDLE; endproperty
  a_off: assert property (p_off) else $error("start while off");
  // a completion with the enable set must reach the request line next cycle
  property p_irq; @(posedge clk_i) disable iff (rst_i)
    (finish && !abort && ien_r) |=> irq_o; endproperty
  a_irq: assert property (p_irq) else $error("irq wrong");
  property p_rec; @(posedge clk_i) disable iff (rst_i)
    (st_r == ASC_RECOV) |-> tad_cnt_r < 4'(ASC_ABORT_TAD); endproperty
  a_rec: assert property (p_rec) else $error("recovery long");
  property p_len; @(posedge clk_i) disable iff (rst_i)
    (st_r == ASC_CONV) |-> tad_cnt_r < 4'(ASC_CONV_TAD); endproperty
  a_len: assert property (p_len) else $error("conversion long");
  property p_sleep; @(posedge clk_i) disable iff (rst_i)
    (busy && sleep_kill) |=> st_r == ASC_RECOV && on == $past(on); endproperty
  a_sleep: assert property (p_sleep) else $error("sleep abort");
  property p_ack; @(posedge clk_i) disable iff (rst_i)
    wb_ack_o |=> !wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("ack held"); // single-cycle bus ack
  // ----------------------------------------------------------------
  // phase length checks
  // ----------------------------------------------------------------
  // clocks spent in the current state; restarts with every state change
  logic [15:0] phase_len_r;
  wire [15:0] per = rc_sel ? 16'(RC_DIV) : {9'h000, ratio};
  always_ff @(posedge clk_i) begin
    if (rst_i || st_nxt != st_r) begin
      phase_len_r <= 16'h0000;
    end else begin
      phase_len_r <= phase_len_r + 16'h0001;
    end
  end
  // the whole conversion, divider included, must span eleven periods
  property p_conv_len; @(posedge clk_i) disable iff (rst_i)
    finish |-> phase_len_r == 16'(ASC_CONV_TAD) * per - 16'h0001; endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length");
  property p_rec_len; @(posedge clk_i) disable iff (rst_i)
    (st_r == ASC_RECOV && st_nxt == ASC_IDLE) |->
      phase_len_r == 16'(ASC_ABORT_TAD) * per - 16'h0001; endproperty
  a_rec_len: assert property (p_rec_len) else $error("recovery length");
  // sequencing: start on go, rc start waits for the instruction tick
  property p_start; @(posedge clk_i) disable iff (rst_i)
    (st_r == ASC_IDLE && go && on && !sleep_kill) |=> busy; endproperty
  a_start: assert property (p_start) else $error("go did not start");
  property p_wait; @(posedge clk_i) disable iff (rst_i)
    (st_r == ASC_WAIT && !abort && !instr_tick_i) |=> st_r == ASC_WAIT; endproperty
  a_wait: assert property (p_wait) else $error("rc start early");
  // justification leaves the unused six bits of the short byte at zero
  property p_right; @(posedge clk_i) disable iff (rst_i)
    (finish && !abort && ctrl0_r[ASC_JUST_BIT]) |=> res_hi_r[7:2] == 6'h00; endproperty
  a_right: assert property (p_right) else $error("right justify");
  property p_left; @(posedge clk_i) disable iff (rst_i)
    (finish && !abort && !ctrl0_r[ASC_JUST_BIT]) |=> res_lo_r[5:0] == 6'h00; endproperty
  a_left: assert property (p_left) else $error("left justify");
  // an abort must leave the previous result untouched through recovery
  property p_hold; @(posedge clk_i) disable iff (rst_i)
    (st_r == ASC_RECOV) |=> $stable(res_hi_r) && $stable(res_lo_r); endproperty
  a_hold: assert property (p_hold) else $error("result changed in recovery");
  c_done: cover property (@(posedge clk_i) finish && !abort);
  c_sleep: cover property (@(posedge clk_i) busy && sleep_kill);
  c_right: cover property (@(posedge clk_i) finish && !abort && ctrl0_r[ASC_JUST_BIT]);
  c_abort: cover property (@(posedge clk_i) st_r == ASC_CONV && abort);
  c_rc: cover property (@(posedge clk_i) st_r == ASC_WAIT && instr_tick_i);
endmodule

/* File: asc_core_model.sv */
// asc_core_model: behavioural analog front end facing the sequencer.
// assumes one comparator decision is wanted per step pulse, msb first.
`timescale 1ns/1ps
module asc_core_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire logic step_i,
  input wire logic [9:0] code_i,
  output logic bit_o
);
  int cnt_r;
  logic junk_r;
  // ----------------------------------------------------------------
  // decision counter, restarted by every acquisition
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    junk_r <= rst_i ? 1'b0 : ~junk_r;
    if (rst_i || sample_i) begin
      cnt_r <= 0;
    end else if (step_i) begin
      cnt_r <= cnt_r + 1;
    end
  end
  // outside the ten decisions the line toggles so a stray sample shows
  assign bit_o = (cnt_r < 10 && !sample_i) ? code_i[9 - cnt_r] : junk_r;
endmodule

/* File: test_asc_ctrl.sv */
// test_asc_ctrl: self-checking bench for the converter sequencer.
// assumes asc_core_model answers every conversion with conv_code.
`timescale 1ns/1ps
module test_asc_ctrl import asc_pkg::*;;
  localparam int RCD = 320;  // rc period at the 1.6 us floor; divided codes only prove ratios
  logic clk_i, rst_i = 1'b1, wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
  logic sleep_i = 1'b0, instr_tick_i = 1'b0, sar_bit_i, wb_ack_o, irq_o, irq_exp;
  logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, wb_dat_o;
  logic [3:0] wb_sel_i = 4'hF, sel_lane = 4'hF;
  logic [2:0] input_channel_select_o;
  logic reference_source_select_o, converter_power_on_o, sample_o, sar_step_o;
  logic [7:0] pin_analog_enable_o;
  logic [5:0] port_a_direction_o;
  logic [9:0] conv_code = 10'h0, last_code;
  logic [63:0] notes[$];
  logic [63:0] note;
  logic [2:0] ck[8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
  int n_errors = 0, check_count = 0, steps = 0, t_first, t_last, cyc = 0;
  asc_ctrl #(.RC_DIV(RCD)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .sleep_i(sleep_i),
    .instr_tick_i(instr_tick_i), .sar_bit_i(sar_bit_i),
    .input_channel_select_o(input_channel_select_o),
    .reference_source_select_o(reference_source_select_o),
    .converter_power_on_o(converter_power_on_o), .sample_o(sample_o),
    .sar_step_o(sar_step_o), .pin_analog_enable_o(pin_analog_enable_o),
    .port_a_direction_o(port_a_direction_o), .irq_o(irq_o));
  asc_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .sample_i(sample_o),
    .step_i(sar_step_o), .code_i(conv_code), .bit_o(sar_bit_i));
  // ----------------------------------------------------------------
  // clock, instruction ticks, watchers
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) instr_tick_i <= (cyc % 16 == 0);
  // step times sampled on the falling edge, clear of the launching edge
  always @(negedge clk_i) begin
    cyc++;
    if (sar_step_o === 1'b1) begin
      if (steps == 0) t_first = cyc;
      t_last = cyc;
      steps++;
    end
  end
  // oldest note meets each read answer; an all-zero mask means poll only
  always @(posedge clk_i) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[63:32] != 32'h0) check("read", wb_dat_o & note[63:32], note[31:0]);
    end
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic test_done(input logic hung);
    if (hung) n_errors++;
    if (n_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // one classic cycle; ack is a flop, so its pre-edge value is what the edge samples
  task automatic bus(input logic [7:0] idx, input logic w, input logic [7:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i, wb_adr_i, wb_dat_i} <=
      {2'b11, w, sel_lane, 22'h0, idx, 2'b00, 24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 50) test_done(1'b1);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, d, q);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] q;
    notes.push_back({m, e});
    bus(idx, 1'b0, 8'h00, q);
  endtask
  task automatic wait_idle();
    logic [31:0] q;
    int n;
    n = 0;
    do begin
      notes.push_back(64'h0);
      bus(ASC_CTRL0_OFS, 1'b0, 8'h00, q);
      n++;
    end while (q[ASC_GO_BIT] !== 1'b0 && n < 2000);
    if (n >= 2000) test_done(1'b1);
  endtask
  function automatic int div_of(input logic [2:0] s);
    if (s[1:0] == 2'b11) return RCD;
    return 2 << {s[1:0], s[2]};
  endfunction
  task automatic convert(input logic [2:0] cks, input logic just, input logic [2:0] ch);
    logic [7:0] c0;
    c0 = {just, 2'b00, ch, 2'b01};
    conv_code <= 10'($urandom);
    sleep_i <= (cks[1:0] == 2'b11);  // rc clock only while asleep
    wr(ASC_CLKCFG_OFS, {1'b0, cks, 4'h0});
    wr(ASC_CTRL0_OFS, c0);  // power up first, go in a later write
    steps = 0;
    wr(ASC_CTRL0_OFS, c0 | 8'h02);
    wait_idle();
    sleep_i <= 1'b0;
    check("steps", steps, 10);
    check("spacing", t_last - t_first, 9 * div_of(cks));
    check("channel", input_channel_select_o, ch);
    check("irq", irq_o, irq_exp);
    rd(ASC_FLAG_OFS, 32'h40, 32'h40);
    rd(ASC_RESHI_OFS, just ? {30'h0, conv_code[9:8]} : {24'h0, conv_code[9:2]}, 32'hFF);
    rd(ASC_RESLO_OFS, just ? {24'h0, conv_code[7:0]} : {24'h0, conv_code[1:0], 6'h0}, 32'hFF);
    wr(ASC_FLAG_OFS, 8'h00);
    last_code = conv_code;
  endtask
  // start a slow conversion of a fresh code and return partway through, still running
  task automatic start_mid();
    wr(ASC_CLKCFG_OFS, 8'h60);
    wr(ASC_CTRL0_OFS, 8'h81);
    conv_code <= ~last_code;
    wr(ASC_CTRL0_OFS, 8'h83);
    repeat (200) @(posedge clk_i);
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(32'h763C));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ASC_CTRL0_OFS, 32'h0, 32'hFFFFFFFF);
    rd(ASC_PINSEL_OFS, 32'hFF, 32'hFFFFFFFF);
    rd(ASC_DIR_OFS, 32'h3F, 32'hFFFFFFFF);
    rd(8'h40, 32'h0, 32'hFFFFFFFF);  // unmapped index reads zero
    wr(ASC_CTRL0_OFS, 8'hFD);
    rd(ASC_CTRL0_OFS, 32'hDD, 32'hFFFFFFFF);
    check("ref", {reference_source_select_o, converter_power_on_o}, 2'b11);
    wr(ASC_PINSEL_OFS, 8'h5A);
    wr(ASC_DIR_OFS, 8'h15);
    @(posedge clk_i);
    check("pins", {pin_analog_enable_o, 2'b00, port_a_direction_o}, 16'h5A15);
    sel_lane = 4'h0;
    wr(ASC_PINSEL_OFS, 8'h00);  // lane 0 off: write dropped, ack still given
    sel_lane = 4'hF;
    rd(ASC_PINSEL_OFS, 32'h5A, 32'hFF);
    wr(ASC_CTRL0_OFS, 8'h02);  // go while off
    rd(ASC_CTRL0_OFS, 32'h0, 32'h3);
    rd(ASC_FLAG_OFS, 32'h0, 32'h40);
    wr(ASC_IEN_OFS, 8'h40);
    for (int i = 0; i < 8; i++) begin
      if (i == 4) wr(ASC_IEN_OFS, 8'h00);
      irq_exp = (i < 4);
      convert(ck[i], i[0], 3'(i));
    end
    start_mid();
    wr(ASC_CTRL0_OFS, 8'h81);  // abort by clearing go
    repeat (64) @(posedge clk_i);
    check("recover", sample_o, 1'b0);
    repeat (70) @(posedge clk_i);
    check("acquire", sample_o, 1'b1);
    rd(ASC_RESLO_OFS, {24'h0, last_code[7:0]}, 32'hFF);
    rd(ASC_FLAG_OFS, 32'h0, 32'h40);
    start_mid();
    sleep_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    check("sleep off", converter_power_on_o, 1'b0);
    rd(ASC_CTRL0_OFS, 32'h1, 32'h3);
    rd(ASC_RESLO_OFS, {24'h0, last_code[7:0]}, 32'hFF);
    sleep_i <= 1'b0;
    start_mid();
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ASC_CTRL0_OFS, 32'h0, 32'hFF);
    rd(ASC_RESLO_OFS, {24'h0, last_code[7:0]}, 32'hFF);
    test_done(1'b0);
  end
endmodule
